// *** rtl/sadc_defs.vh ***
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH

// Register offsets on the plain register port
`define SADC_OFF_CTRL_A 8'h1f
`define SADC_OFF_PIN_CFG 8'h9f
`define SADC_OFF_RESULT 8'h1e
`define SADC_OFF_STATUS 8'h0c

// adc_control_a field positions
`define SADC_CA_CLK_HI 7
`define SADC_CA_CLK_LO 6
`define SADC_CA_CHAN_HI 5
`define SADC_CA_CHAN_LO 3
`define SADC_CA_GO 2
`define SADC_CA_PWR 0

// adc_pin_config field positions
`define SADC_PC_ANA_HI 4
`define SADC_PC_ANA_LO 0
`define SADC_PC_REF 7
`define SADC_REF_PIN 3

// Status register field positions
`define SADC_ST_FLAG 0
`define SADC_ST_IEN 1

// Reset values
`define SADC_RST_CTRL_A 8'h00
`define SADC_RST_PIN_CFG 8'h00
`define SADC_RST_RESULT 8'h00
`define SADC_RST_STATUS 8'h00
`define SADC_RST_CLK_SEL 2'h0

// conv_clock_select codes
`define SADC_CLK_2TOSC 2'h0
`define SADC_CLK_8TOSC 2'h1
`define SADC_CLK_32TOSC 2'h2
`define SADC_CLK_RC 2'h3

// Half bit periods in mclk cycles (2, 8, 32 Tosc)
`define SADC_HALF_2TOSC 5'h01
`define SADC_HALF_8TOSC 5'h04
`define SADC_HALF_32TOSC 5'h10

// Sequence lengths in half bit periods, and the channel count
`define SADC_CONV_HALVES 5'h13
`define SADC_FIRST_STEP 5'h05
`define SADC_RECOV_HALVES 5'h04
`define SADC_NUM_CHAN 3'h5

`endif

// *** rtl/sadc_tadgen.v ***
`timescale 1ns/1ps
`include "sadc_defs.vh"

module sadc_tadgen (
   // Clock and reset
   input wire mclk_i,
   input wire rst_n_i,
   // Control
   input wire run_i,
   input wire [1:0] clk_sel_i,
   input wire rc_tick_i,
   // Half bit period strobe
   output reg half_tick_o
);

   reg [4:0] cnt_r;
   reg [4:0] lim;

   // Divider length for the oscillator-derived sources
   always @* begin
      case (clk_sel_i)
         `SADC_CLK_2TOSC: lim = `SADC_HALF_2TOSC;
         `SADC_CLK_8TOSC: lim = `SADC_HALF_8TOSC;
         default: lim = `SADC_HALF_32TOSC;
      endcase
   end

   // Restarts whenever run drops so each phase begins aligned
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= 5'h00;
         half_tick_o <= 1'b0;
      end else if (!run_i) begin
         cnt_r <= 5'h00;
         half_tick_o <= 1'b0;
      end else if (clk_sel_i == `SADC_CLK_RC) begin
         cnt_r <= 5'h00;
         half_tick_o <= rc_tick_i;
      end else if (cnt_r == lim - 5'h01) begin
         cnt_r <= 5'h00;
         half_tick_o <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 5'h01;
         half_tick_o <= 1'b0;
      end
   end

endmodule

// *** rtl/sadc_sar.v ***
`timescale 1ns/1ps

module sadc_sar (
   // Clock and reset
   input wire mclk_i,
   input wire rst_n_i,
   // Sequencing
   input wire start_i,
   input wire step_i,
   input wire cmp_i,
   // Trial code and end of search
   output reg [7:0] code_o,
   output reg done_o
);

   reg [2:0] idx_r;
   reg [7:0] code_nxt;

   // Keep or drop the trial bit, then try the next lower one
   always @* begin
      code_nxt = code_o;
      code_nxt[idx_r] = cmp_i;
      if (idx_r != 3'h0) begin
         code_nxt[idx_r - 3'h1] = 1'b1;
      end
   end

   // One bit per step, MSB first; done pulses after the LSB
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         code_o <= 8'h00;
         idx_r <= 3'h0;
         done_o <= 1'b0;
      end else if (start_i) begin
         code_o <= 8'h80;
         idx_r <= 3'h7;
         done_o <= 1'b0;
      end else if (step_i) begin
         code_o <= code_nxt;
         idx_r <= idx_r - 3'h1;
         done_o <= (idx_r == 3'h0);
      end else begin
         done_o <= 1'b0;
      end
   end

endmodule

// *** rtl/sadc_top.v ***
`timescale 1ns/1ps
`include "sadc_defs.vh"

module sadc_top (
   // Clock and reset
   input wire mclk_i,
   input wire rst_n_i,
   // Register port
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   // Core status
   input wire sleep_i,
   input wire instr_cycle_i,
   input wire rc_tick_i,
   // Analog front end
   input wire cmp_i,
   output reg [2:0] mux_sel_o,
   output reg hold_conn_o,
   output wire [7:0] dac_code_o,
   output reg ref_ext_o,
   output reg conv_pwr_o,
   output reg [4:0] ana_pin_en_o,
   // Completion interrupt request
   output reg irq_o
);

   // One-hot sequencer states: OFF powered down, ACQ cap on the
   // channel, WRC start delay for RC, CONV search, REC recovery
   localparam [4:0] ST_OFF = 5'h01;
   localparam [4:0] ST_ACQ = 5'h02;
   localparam [4:0] ST_WRC = 5'h04;
   localparam [4:0] ST_CONV = 5'h08;
   localparam [4:0] ST_REC = 5'h10;

   // Software-visible state
   // (status holds the completion flag and its enable)
   reg [1:0] clk_sel_r;
   reg [2:0] chan_r;
   reg go_r;
   reg pwr_r;
   reg [7:0] pin_cfg_r;
   reg [7:0] result_r;
   reg flag_r;
   reg ien_r;

   // Sequencer state
   reg [4:0] state_r;
   reg [4:0] state_nxt;
   reg [4:0] half_cnt_r;

   // Internal strobes
   wire wr_ca;
   wire wr_pc;
   wire wr_res;
   wire wr_st;
   wire rc_sel;
   wire sleep_kill;
   wire half_tick;
   wire tad_run;
   wire sar_start;
   wire sar_step;
   wire sar_done;
   wire conv_done;
   wire conv_abort;
   wire [4:0] half_cnt_inc;

   // Address decode of write strobes
   assign wr_ca = wr_i && (addr_i == `SADC_OFF_CTRL_A);
   assign wr_pc = wr_i && (addr_i == `SADC_OFF_PIN_CFG);
   assign wr_res = wr_i && (addr_i == `SADC_OFF_RESULT);
   assign wr_st = wr_i && (addr_i == `SADC_OFF_STATUS);

   // Only the RC source keeps running once the core clock stops
   assign rc_sel = (clk_sel_r == `SADC_CLK_RC);
   assign sleep_kill = sleep_i && !rc_sel;

   // Bit timer restarts on every state change
   assign tad_run = (state_r == state_nxt) &&
                    ((state_r == ST_CONV) || (state_r == ST_REC));
   assign half_cnt_inc = half_cnt_r + 5'h01;

   // First trial bit goes out as the conversion begins
   // (from ACQ directly or from the RC start delay)
   assign sar_start = (state_r != ST_CONV) && (state_nxt == ST_CONV);

   // 2.5 periods of hold, then a bit decision every full period
   assign sar_step = (state_r == ST_CONV) && half_tick &&
                     (half_cnt_inc >= `SADC_FIRST_STEP) &&
                     half_cnt_inc[0];

   // Completion needs both the last bit and a still-set busy bit
   assign conv_done = (state_r == ST_CONV) && sar_done && go_r &&
                      pwr_r && !sleep_kill;
   // Any clear of busy while searching or waiting drops the run;
   // the partial code never reaches the result register
   assign conv_abort = ((state_r == ST_CONV) || (state_r == ST_WRC)) &&
                       !go_r;

   // Bit period generator; the dividers count mclk, while the RC
   // source only forwards its own ticks
   sadc_tadgen u_tadgen (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .run_i(tad_run),
      .clk_sel_i(clk_sel_r),
      .rc_tick_i(rc_tick_i),
      .half_tick_o(half_tick)
   );

   // Successive-approximation register; its trial code drives the
   // reference ladder directly and is already registered inside
   sadc_sar u_sar (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .start_i(sar_start),
      .step_i(sar_step),
      .cmp_i(cmp_i),
      .code_o(dac_code_o),
      .done_o(sar_done)
   );

   // Sequencer next state; power loss overrides everything
   always @* begin
      state_nxt = state_r;
      if (!pwr_r || sleep_kill) begin
         state_nxt = ST_OFF;
      end else begin
         case (state_r)
            ST_OFF: begin
               state_nxt = ST_ACQ;
            end
            ST_ACQ: begin
               if (go_r && rc_sel) begin
                  state_nxt = ST_WRC;
               end else if (go_r) begin
                  state_nxt = ST_CONV;
               end
            end
            ST_WRC: begin
               // Wait for an instruction edge so the core can go quiet
               if (!go_r) begin
                  state_nxt = ST_REC;
               end else if (instr_cycle_i) begin
                  state_nxt = ST_CONV;
               end
            end
            ST_CONV: begin
               if (conv_abort || conv_done) begin
                  state_nxt = ST_REC;
               end
            end
            ST_REC: begin
               // Two bit periods with the cap off before acquiring
               if (half_tick &&
                   half_cnt_inc == `SADC_RECOV_HALVES) begin
                  state_nxt = ST_ACQ;
               end
            end
            default: begin
               state_nxt = ST_OFF;
            end
         endcase
      end
   end

   // State and half-period counter; the count restarts on every
   // state change, so each phase is timed from its own first edge
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= ST_OFF;
         half_cnt_r <= 5'h00;
      end else begin
         state_r <= state_nxt;
         if (state_r != state_nxt) begin
            half_cnt_r <= 5'h00;
         end else if (half_tick) begin
            half_cnt_r <= half_cnt_inc;
         end
      end
   end

   // Control register A; a software set of busy beats a hardware clear
   // so a start written in the completing cycle is never lost
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_sel_r <= `SADC_RST_CLK_SEL;
         chan_r <= 3'h0;
         go_r <= 1'b0;
         pwr_r <= 1'b0;
      end else begin
         if (wr_ca) begin
            clk_sel_r <= wdata_i[`SADC_CA_CLK_HI:`SADC_CA_CLK_LO];
            chan_r <= wdata_i[`SADC_CA_CHAN_HI:`SADC_CA_CHAN_LO];
            pwr_r <= wdata_i[`SADC_CA_PWR];
         end
         if (wr_ca && wdata_i[`SADC_CA_GO]) begin
            go_r <= 1'b1;
         end else if (wr_ca) begin
            go_r <= 1'b0;
         end else if (conv_done || sleep_kill) begin
            go_r <= 1'b0;
         end
      end
   end

   // Pin configuration register
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_cfg_r <= `SADC_RST_PIN_CFG;
      end else if (wr_pc) begin
         pin_cfg_r <= wdata_i;
      end
   end

   // Result: hardware load wins; an aborted run never loads
   // A software write landing in the completing cycle is dropped
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result_r <= `SADC_RST_RESULT;
      end else if (conv_done) begin
         result_r <= dac_code_o;
      end else if (wr_res) begin
         result_r <= wdata_i;
      end
   end

   // Completion flag and enable; completion beats a clear
   // so software can never miss a finished conversion
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_r <= 1'b0;
         ien_r <= 1'b0;
      end else begin
         if (conv_done) begin
            flag_r <= 1'b1;
         end else if (wr_st) begin
            flag_r <= wdata_i[`SADC_ST_FLAG];
         end
         if (wr_st) begin
            ien_r <= wdata_i[`SADC_ST_IEN];
         end
      end
   end

   // Read data stand for one cycle only; unmapped reads give zero
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         case (addr_i)
            `SADC_OFF_CTRL_A: begin
               rdata_o <= {clk_sel_r, chan_r, go_r, 1'b0, pwr_r};
            end
            `SADC_OFF_PIN_CFG: begin
               rdata_o <= pin_cfg_r;
            end
            `SADC_OFF_RESULT: begin
               rdata_o <= result_r;
            end
            `SADC_OFF_STATUS: begin
               rdata_o <= {6'h00, ien_r, flag_r};
            end
            default: begin
               rdata_o <= 8'h00;
            end
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // Analog side; the hold cap only connects while acquiring and
   // keeps its charge otherwise since nothing here discharges it
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mux_sel_o <= 3'h0;
         hold_conn_o <= 1'b0;
         ref_ext_o <= 1'b0;
      end else begin
         mux_sel_o <= chan_r;
         hold_conn_o <= (state_nxt == ST_ACQ) &&
                        (chan_r < `SADC_NUM_CHAN);
         ref_ext_o <= pin_cfg_r[`SADC_PC_REF];
      end
   end

   // Power and request; taken from the next state so the converter
   // powers down in the same cycle as the sequencer goes off
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         conv_pwr_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         conv_pwr_o <= (state_nxt != ST_OFF);
         irq_o <= flag_r && ien_r;
      end
   end

   // Per-pin analog enable; reference pin is analog when chosen
   // so it can never be left acting as digital I/O
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_pin
         always @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               ana_pin_en_o[gi] <= 1'b0;
            end else begin
               ana_pin_en_o[gi] <= pin_cfg_r[`SADC_PC_ANA_LO + gi] ||
                  (pin_cfg_r[`SADC_PC_REF] &&
                   gi == `SADC_REF_PIN);
            end
         end
      end
   endgenerate

endmodule

// *** tb/sadc_src.sv ***
`timescale 1ns/1ps

module sadc_src (
   // Clock
   input wire mclk_i,
   // Front end controls from the converter
   input wire [2:0] mux_sel_i,
   input wire hold_conn_i,
   input wire [7:0] dac_code_i,
   // Source levels, eight bits per channel; the pins are only read
   input wire [39:0] lvl_i,
   // Comparator decision
   output wire cmp_o
);
   // Arbitrary leftover charge until the first acquisition
   reg [7:0] held_r = 8'ha5;

   // Cap follows the channel only while switched in, never discharged
   always @(posedge mclk_i) begin
      if (hold_conn_i && mux_sel_i < 3'h5)
         held_r <= lvl_i[mux_sel_i*8 +: 8];
   end

   // Ideal comparator: no offset, so the search lands on the level
   assign cmp_o = held_r >= dac_code_i;
endmodule

// *** tb/sadc_top_chk.sv ***
`timescale 1ns/1ps
`include "sadc_defs.vh"

module sadc_chk (
   // Clock and reset
   input wire mclk_i,
   input wire rst_n_i,
   // Register port
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   // Core status
   input wire sleep_i,
   // Front end and request
   input wire [2:0] mux_sel_o,
   input wire hold_conn_o,
   input wire [7:0] dac_code_o,
   input wire ref_ext_o,
   input wire conv_pwr_o,
   input wire [4:0] ana_pin_en_o,
   input wire irq_o
);
   reg [1:0] csel_r;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   // Shadow of the clock select, needed to judge sleep behaviour
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         csel_r <= 2'h0;
      else if (wr_i && addr_i == `SADC_OFF_CTRL_A)
         csel_r <= wdata_i[7:6];
   end

   a_rd_zero: assert property (
      !$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside read slot");
   a_hold_chan: assert property (
      hold_conn_o |-> mux_sel_o < 3'h5)
      else $error("hold cap on invalid channel");
   a_hold_pwr: assert property (
      !conv_pwr_o |-> !hold_conn_o)
      else $error("hold cap connected while off");
   a_hold_gap: assert property (
      $fell(hold_conn_o) && conv_pwr_o && mux_sel_o < 3'h5
      |-> !hold_conn_o [*4])
      else $error("hold cap reconnected during recovery");
   a_dac_acq: assert property (
      hold_conn_o && $past(hold_conn_o) |-> $stable(dac_code_o))
      else $error("trial code moved during acquisition");
   a_pin_ref: assert property (
      wr_i && addr_i == `SADC_OFF_PIN_CFG && wdata_i[7]
      |-> ##[1:2] (ref_ext_o && ana_pin_en_o[3]))
      else $error("reference pin not taken");
   a_irq_keep: assert property (
      irq_o && !wr_i && !$past(wr_i) |=> irq_o)
      else $error("irq dropped without a write");
   a_sleep_off: assert property (
      sleep_i && csel_r != `SADC_CLK_RC |-> ##[1:2] !conv_pwr_o)
      else $error("converter kept on in sleep");
   a_rc_sleep: assert property (
      sleep_i && csel_r == `SADC_CLK_RC && conv_pwr_o && !wr_i
      |=> conv_pwr_o)
      else $error("rc converter lost power in sleep");
   a_pwr_on: assert property (
      wr_i && addr_i == `SADC_OFF_CTRL_A && wdata_i[0] && !sleep_i
      |-> ##[1:3] conv_pwr_o)
      else $error("converter did not power up");

   c_irq: cover property ($rose(irq_o));
   c_rc: cover property (sleep_i && csel_r == `SADC_CLK_RC && conv_pwr_o);
   c_ref: cover property ($rose(ref_ext_o));
endmodule

bind sadc_top sadc_chk i_sadc_chk (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .sleep_i(sleep_i), .mux_sel_o(mux_sel_o), .hold_conn_o(hold_conn_o),
   .dac_code_o(dac_code_o), .ref_ext_o(ref_ext_o),
   .conv_pwr_o(conv_pwr_o), .ana_pin_en_o(ana_pin_en_o), .irq_o(irq_o));

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "sadc_defs.vh"

module tb;
   localparam [7:0] OCA = `SADC_OFF_CTRL_A;
   localparam [7:0] OPC = `SADC_OFF_PIN_CFG;
   localparam [7:0] ORS = `SADC_OFF_RESULT;
   localparam [7:0] OST = `SADC_OFF_STATUS;
   reg mclk_i = 1'b0;
   reg rst_n = 1'b0;
   reg [7:0] addr = 8'h00, wdata = 8'h00;
   reg wr = 1'b0, rd = 1'b0, slp = 1'b0, icyc = 1'b0, rct = 1'b0;
   reg [39:0] lvl = 40'h0;
   reg [7:0] v, m_res, m_st;
   reg [7:0] ofs [0:4];
   reg [7:0] res_q [$];
   wire [7:0] rdata, dac;
   wire [2:0] mux;
   wire [4:0] ape;
   wire cmp, hold, rfx, pwr, irq;
   integer n_errors = 0, check_count = 0, cyc = 0, i, t;

   sadc_top i_sadc_top (.mclk_i(mclk_i), .rst_n_i(rst_n), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .sleep_i(slp), .instr_cycle_i(icyc), .rc_tick_i(rct), .cmp_i(cmp),
      .mux_sel_o(mux), .hold_conn_o(hold), .dac_code_o(dac),
      .ref_ext_o(rfx), .conv_pwr_o(pwr), .ana_pin_en_o(ape), .irq_o(irq));
   sadc_src i_sadc_src (.mclk_i(mclk_i), .mux_sel_i(mux),
      .hold_conn_i(hold), .dac_code_i(dac), .lvl_i(lvl), .cmp_o(cmp));

   // Clock, 100 MHz
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end

   // Cycle count, RC ticks every 3 cycles, instruction edge every 4
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      rct <= (cyc % 3 == 0);
      icyc <= (cyc % 4 == 1);
   end

   task close_out;
      begin
         $display("checks %0d errors %0d", check_count, n_errors);
         if (n_errors == 0 && check_count > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask

   // A bound ran out: count it and stop
   task tmo;
      begin
         n_errors = n_errors + 1;
         close_out;
      end
   endtask

   task chk(input string nm, input [7:0] seen, input [7:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("Error %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask

   task wr8(input [7:0] a, input [7:0] d);
      begin
         @(posedge mclk_i);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge mclk_i);
         wr <= 1'b0;
      end
   endtask

   // Data stand only in the cycle after the strobe
   task rd8(input [7:0] a, output [7:0] d);
      begin
         @(posedge mclk_i);
         addr <= a;
         rd <= 1'b1;
         @(posedge mclk_i);
         rd <= 1'b0;
         #1 d = rdata;
      end
   endtask

   task rchk(input string nm, input [7:0] a, input [7:0] e);
      reg [7:0] d;
      begin
         rd8(a, d);
         chk(nm, d, e);
      end
   endtask

   // Waits for the cap to reconnect; leaves the count in t
   task wait_acq;
      begin
         for (t = 0; t < 300 && hold !== 1'b1; t = t + 1) begin
            @(posedge mclk_i);
            #1;
         end
         if (t == 300)
            tmo;
      end
   endtask

   // One conversion on a random channel and level; h is cycles per half
   task conv(input [1:0] sel, input integer h, input s);
      integer ch, t0;
      begin
         ch = $urandom % 5;
         m_res = $urandom;
         lvl[ch*8 +: 8] <= m_res;
         res_q.push_back(m_res);
         wr8(OCA, {sel, ch[2:0], 3'b001});
         // Acquisition wait sized for a stiff source on a small cap
         repeat (8) @(posedge mclk_i);
         chk("mux", mux, ch[7:0]);
         wr8(OCA, {sel, ch[2:0], 3'b101});
         t0 = cyc;
         slp <= s;
         v = 8'h04;
         for (i = 0; i < 400 && v[2]; i = i + 1)
            rd8(OCA, v);
         if (v[2])
            tmo;
         t0 = cyc - t0;
         slp <= 1'b0;
         chk("hold", hold, 8'h00);
         chk("len", t0 >= 19*h && t0 <= 19*h + 12, 8'h01);
         wait_acq;
         chk("rec", t + 3 >= 4*h, 8'h01);
         m_st[0] = 1'b1;
         v = res_q.pop_front();
         rchk("result", ORS, v);
         rchk("status", OST, m_st);
         rchk("ctrl", OCA, {sel, ch[2:0], 3'b001});
         chk("irq", irq, m_st[0] & m_st[1]);
      end
   endtask

   initial begin
      t = $urandom(32'h023c);
      m_st = 8'h00;
      ofs = '{OCA, OPC, ORS, OST, 8'h55};
      repeat (5) @(posedge mclk_i);
      rst_n <= 1'b1;
      // Reset values, with one unmapped place last
      for (i = 0; i < 5; i = i + 1)
         rchk("rst", ofs[i], 8'h00);
      // Pin roles: reference pin on, then off
      for (i = 0; i < 2; i = i + 1) begin
         v = ($urandom & 8'h7f) | (i[0] ? 8'h00 : 8'h80);
         wr8(OPC, v);
         rchk("pin", OPC, v);
         chk("ref", rfx, {7'h0, v[7]});
         chk("ana", ape, v[4:0] | {v[7], 3'h0});
      end
      // Bit 1 of control reads 0; result is writable
      wr8(OCA, 8'hfa);
      rchk("ctrl1", OCA, 8'hf8);
      m_res = $urandom;
      wr8(ORS, m_res);
      rchk("res_w", ORS, m_res);
      // Divided clocks, then RC while the core sleeps
      conv(`SADC_CLK_2TOSC, 1, 1'b0);
      // Reading the result leaves the flag; then clear it and enable
      m_st = 8'h03;
      wr8(OST, m_st);
      rchk("res_rd", ORS, m_res);
      chk("irq_on", irq, 8'h01);
      m_st = 8'h02;
      wr8(OST, m_st);
      rchk("st_clr", OST, m_st);
      chk("irq_off", irq, 8'h00);
      conv(`SADC_CLK_8TOSC, 4, 1'b0);
      conv(`SADC_CLK_32TOSC, 16, 1'b0);
      conv(`SADC_CLK_RC, 3, 1'b1);
      // Abort by clearing go mid conversion
      wr8(OCA, 8'h89);
      repeat (8) @(posedge mclk_i);
      wr8(OCA, 8'h8d);
      repeat (40) @(posedge mclk_i);
      wr8(OCA, 8'h89);
      chk("ab_hold", hold, 8'h00);
      rchk("ab_res", ORS, m_res);
      rchk("ab_st", OST, m_st);
      wait_acq;
      chk("ab_rec", t + 8 >= 64, 8'h01);
      // Sleep on a divided clock aborts and powers down
      wr8(OCA, 8'h0d);
      repeat (4) @(posedge mclk_i);
      slp <= 1'b1;
      repeat (4) @(posedge mclk_i);
      chk("sl_pwr", pwr, 8'h00);
      rchk("sl_ctrl", OCA, 8'h09);
      rchk("sl_res", ORS, m_res);
      slp <= 1'b0;
      repeat (4) @(posedge mclk_i);
      chk("wake", pwr, 8'h01);
      close_out;
   end

   // Run limit
   initial begin
      repeat (100000) @(posedge mclk_i);
      tmo;
   end
endmodule
